//--- logic/tvs_pkg.sv
// constants, field layouts and carriers of the text video serializer
// assumes one 125 MHz clock and a display controller on the same clock
//
// How it works
// - cpu address to video memory when selected
// - cpu data buffers enabled only for selected memory
// - attribute memory keeps two bits, rest read high
// - character code latched at char strobe
// - raster row low bits address glyph row
// - glyph row shifted out one pixel per dot
// - attribute delayed two char strobes
// - reverse attribute inverts cell pixels
// - blink gates pixels with vsync divided by 64
// - pixels gated by display window
// - composite sync merged with gated pixels
// - hold request low while allowed and displaying
// - display period readable as retrace flag
// - char strobe once per eight dots
// - dot rate 16 MHz, halved in 40 columns
package tvs_pkg;

	// ======================================================
	// dot clock generation
	localparam int             CLK_MHZ = 125;   // ref_clk rate
	localparam int             DOT_MHZ = 16;    // full dot rate
	localparam logic [7:0]     ACC_MOD = 8'(CLK_MHZ);
	localparam logic [7:0]     STEP_80 = 8'(DOT_MHZ);
	localparam logic [7:0]     STEP_40 = 8'(DOT_MHZ / 2);
	localparam logic [7:0]     ACC_RST = 8'h00;
	localparam logic [2:0]     PH_LAST = 3'h7;  // eighth dot of a cell
	localparam logic [5:0]     BLINK_RST = 6'h00; // 64 frames per wrap

	// ======================================================
	// register map, byte addresses
	localparam logic [3:0]     REG_CTRL   = 4'h0;
	localparam logic [3:0]     REG_STATUS = 4'h4;
	localparam int             CTRL_COL80 = 0;  // 80 column mode
	localparam int             CTRL_HOLD  = 1;  // hold_allow
	localparam logic [1:0]     CTRL_RST   = 2'h0;
	localparam int             STAT_RETR  = 0;  // retrace_flag
	localparam int             STAT_BLINK = 1;  // blink phase

	// ======================================================
	// attribute layout
	localparam int             ATTR_REV   = 0;
	localparam int             ATTR_BLINK = 1;
	localparam logic [5:0]     ATTR_FILL  = 6'h3F; // undriven bits

	// ======================================================
	// carriers
	typedef struct packed {
		logic        hsync;          // active high line sync
		logic        vsync;          // active high frame sync
		logic        display_window; // visible area
		logic [4:0]  raster_row;     // scan line in char row
		logic [13:0] refresh_addr;   // screen memory walk
	} tvs_crtc_s;

	typedef struct packed {
		logic sync_n;  // composite sync, low during sync
		logic pixel;   // gated video dot
	} tvs_video_s;

endpackage

//--- logic/tvs_serializer.sv
// text video back end: video memory arbitration, glyph serializer,
// attributes, composite video and cpu hold during display
// assumes display controller and cpu signals synchronous to ref_clk
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
module tvs_serializer #(
	parameter int AW = 11          // video memory address width
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst_b,
	input  wire logic [3:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	input  wire logic [3:0]            avs_byteenable,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	input  wire tvs_pkg::tvs_crtc_s    crtc,
	input  wire logic [AW-1:0]         cpu_addr,
	input  wire logic                  cpu_vram_sel_n,
	input  wire logic                  cpu_character_ram_sel_n,
	input  wire logic                  cpu_attribute_ram_sel_n,
	input  wire logic                  cpu_rd_n,
	input  wire logic                  cpu_wr_n,
	input  wire logic [7:0]            cpu_data_in,
	output logic      [7:0]            cpu_data_out,
	output logic                       cpu_data_oe,
	output logic      [10:0]           cg_addr,
	input  wire logic [7:0]            cg_data,
	output tvs_pkg::tvs_video_s        video,
	output logic                       bus_hold_request_n
);

	// ======================================================
	// storage and state
	logic [7:0]      char_mem [2**AW];  // character_ram
	logic [1:0]      attr_mem [2**AW];  // attribute_ram
	logic [AW-1:0]   vram_addr;         // muxed address
	logic [7:0]      rd_char;           // registered char read
	logic [1:0]      rd_attr;           // registered attr read
	logic [1:0]      ctrl;              // software control
	logic            ack;               // bus answer phase
	logic [7:0]      acc;               // dot phase accumulator
	logic [7:0]      next_acc;
	logic            dot_en;            // one pulse per dot
	logic [2:0]      dot_phase;         // dot within cell
	logic            char_strobe;       // one pulse per cell
	logic [7:0]      code_latch;        // character code
	logic [1:0]      attr_d1;           // attribute delay stages
	logic [1:0]      attr_d2;
	logic [7:0]      shifter;           // glyph row shifter
	logic            vsync_q;           // edge detect
	logic [5:0]      blink_cnt;         // vsync divider
	logic            blink_sig;         // about 1 Hz
	logic            vdisp;             // vertical display period
	logic            pix;               // combined pixel

	// ======================================================
	// address multiplexer, cpu wins while it selects vram
	assign vram_addr = !cpu_vram_sel_n ? cpu_addr :
		crtc.refresh_addr[AW-1:0];

	// memory writes from cpu only; no reset on the arrays
	always_ff @(posedge ref_clk) begin
		if (!cpu_vram_sel_n && !cpu_wr_n) begin
			if (!cpu_character_ram_sel_n) begin
				char_mem[vram_addr] <= cpu_data_in;
			end
			if (!cpu_attribute_ram_sel_n) begin
				attr_mem[vram_addr] <= cpu_data_in[1:0];
			end
		end
	end

	// synchronous read for the display at the shared address
	always_ff @(posedge ref_clk) begin
		rd_char <= char_mem[vram_addr];
		rd_attr <= attr_mem[vram_addr];
	end

	// cpu data buffers, isolated unless a memory is selected
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cpu_data_oe  <= 1'b0;
			cpu_data_out <= 8'h00;
		end else begin
			cpu_data_oe <= !cpu_vram_sel_n && !cpu_rd_n &&
				(!cpu_character_ram_sel_n || !cpu_attribute_ram_sel_n);
			if (!cpu_attribute_ram_sel_n) begin
				// unused attribute lines float high
				cpu_data_out <= {tvs_pkg::ATTR_FILL,
					attr_mem[vram_addr]};
			end else begin
				cpu_data_out <= char_mem[vram_addr];
			end
		end
	end

	// ======================================================
	// avalon slave: one wait cycle then the answer
	assign avs_waitrequest = (avs_read || avs_write) && !ack;

	// answer phase toggles so each request sees one wait state
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ack <= 1'b0;
		end else begin
			ack <= (avs_read || avs_write) && !ack;
		end
	end

	// control register, written only in the answer cycle
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= tvs_pkg::CTRL_RST;
		end else if (avs_write && ack && avs_byteenable[0] &&
			avs_address == tvs_pkg::REG_CTRL) begin
			ctrl <= avs_writedata[1:0];
		end
	end

	// read data captured in the wait cycle; unmapped reads zero
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && !ack) begin
			avs_readdata <= 32'h0000_0000;
			case (avs_address)
				tvs_pkg::REG_CTRL: begin
					avs_readdata[1:0] <= ctrl;
				end
				tvs_pkg::REG_STATUS: begin
					avs_readdata[tvs_pkg::STAT_RETR]  <= vdisp;
					avs_readdata[tvs_pkg::STAT_BLINK] <= blink_sig;
				end
				default: begin
					avs_readdata <= 32'h0000_0000;
				end
			endcase
		end
	end

	// ======================================================
	// dot enable: fractional divider since 125/16 is not whole
	always_comb begin
		next_acc = acc + (ctrl[tvs_pkg::CTRL_COL80] ?
			tvs_pkg::STEP_80 : tvs_pkg::STEP_40);
	end

	// jitter of one ref_clk cycle per dot is the trade-off here
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			acc    <= tvs_pkg::ACC_RST;
			dot_en <= 1'b0;
		end else if (next_acc >= tvs_pkg::ACC_MOD) begin
			acc    <= next_acc - tvs_pkg::ACC_MOD;
			dot_en <= 1'b1;
		end else begin
			acc    <= next_acc;
			dot_en <= 1'b0;
		end
	end

	// cell phase counter
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dot_phase <= 3'h0;
		end else if (dot_en) begin
			dot_phase <= dot_phase + 3'h1;
		end
	end

	assign char_strobe = dot_en && dot_phase == tvs_pkg::PH_LAST;

	// ======================================================
	// character fetch and attribute pipeline
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			code_latch <= 8'h00;
			attr_d1    <= 2'h0;
			attr_d2    <= 2'h0;
		end else if (char_strobe) begin
			code_latch <= rd_char;
			attr_d1    <= rd_attr;
			attr_d2    <= attr_d1;
		end
	end

	// generator address: code on top, scan line below
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cg_addr <= 11'h000;
		end else begin
			cg_addr <= {code_latch, crtc.raster_row[2:0]};
		end
	end

	// glyph shifter, msb first, reloads on the last dot of a cell
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			shifter <= 8'h00;
		end else if (char_strobe) begin
			shifter <= cg_data;
		end else if (dot_en) begin
			shifter <= {shifter[6:0], 1'b0};
		end
	end

	// ======================================================
	// blink divider and display period
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			vsync_q   <= 1'b0;
			blink_cnt <= tvs_pkg::BLINK_RST;
		end else begin
			vsync_q <= crtc.vsync;
			if (crtc.vsync && !vsync_q) begin
				blink_cnt <= blink_cnt + 6'h01;
			end
		end
	end

	assign blink_sig = blink_cnt[5];

	// display period: opens with the window, closes at vsync
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			vdisp <= 1'b0;
		end else if (crtc.vsync && !vsync_q) begin
			vdisp <= 1'b0;
		end else if (crtc.display_window) begin
			vdisp <= 1'b1;
		end
	end

	// cpu hold keeps vram quiet while characters are drawn
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_hold_request_n <= 1'b1;
		end else begin
			bus_hold_request_n <=
				!(ctrl[tvs_pkg::CTRL_HOLD] && vdisp);
		end
	end

	// ======================================================
	// pixel path and composite output
	always_comb begin
		pix = shifter[7] ^ attr_d2[tvs_pkg::ATTR_REV];
		if (attr_d2[tvs_pkg::ATTR_BLINK]) begin
			pix = pix && blink_sig;
		end
		pix = pix && crtc.display_window;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			video <= '{sync_n: 1'b1, pixel: 1'b0};
		end else begin
			video.pixel  <= pix;
			video.sync_n <= !(crtc.hsync || crtc.vsync);
		end
	end

	// ======================================================
	// checks
	// both attribute stages step together, one strobe apart
	sequence s_attr_step;
		attr_d1 == $past(rd_attr) && attr_d2 == $past(attr_d1);
	endsequence

	a_addr_mux: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cpu_vram_sel_n |-> vram_addr == crtc.refresh_addr[AW-1:0])
		else $error("display address not routed");
	a_buf_iso: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cpu_data_oe |-> $past(!cpu_rd_n && !cpu_vram_sel_n &&
			(!cpu_character_ram_sel_n || !cpu_attribute_ram_sel_n)))
		else $error("data buffer driven without read");
	a_attr_high: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$past(!cpu_attribute_ram_sel_n) |-> cpu_data_out[7:2] == 6'h3F)
		else $error("attribute upper bits not high");
	a_code_latch: assert property (@(posedge ref_clk) disable iff (!rst_b)
		char_strobe |=> code_latch == $past(rd_char) ##1
		cg_addr[10:3] == $past(code_latch))
		else $error("character code not latched");
	a_row_addr: assert property (@(posedge ref_clk) disable iff (!rst_b)
		##1 cg_addr[2:0] == $past(crtc.raster_row[2:0]))
		else $error("glyph row address wrong");
	a_shift_msb: assert property (@(posedge ref_clk) disable iff (!rst_b)
		dot_en && !char_strobe |=> shifter == {$past(shifter[6:0]), 1'b0})
		else $error("shifter not msb first");
	a_attr_delay: assert property (@(posedge ref_clk) disable iff (!rst_b)
		char_strobe |=> s_attr_step)
		else $error("attribute delay broken");
	a_blank_video: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!$past(crtc.display_window) |-> !video.pixel)
		else $error("video outside display window");
	a_strobe_eight: assert property (@(posedge ref_clk) disable iff (!rst_b)
		char_strobe |=> !char_strobe [*8])
		else $error("char strobe too frequent");
	a_hold_req: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ctrl[tvs_pkg::CTRL_HOLD] && vdisp |=> !bus_hold_request_n)
		else $error("hold request missing");
	a_sync_comp: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$past(crtc.hsync) |-> !video.sync_n)
		else $error("composite sync missing");

endmodule

//--- sim/tvs_glyph_rom.sv
// far-side glyph generator model of the text video serializer
// assumes cg_addr from the design, answers one ref_clk later
`timescale 1ns/100ps
module tvs_glyph_rom (
	input  wire logic        ref_clk,
	input  wire logic [10:0] cg_addr,
	output logic      [7:0]  cg_data
);
	// ======================================================
	// registered lookup, glyph row = code xor row, so code 0
	// row 0 gives an empty row and code FF row 0 a full one
	always_ff @(posedge ref_clk) begin
		cg_data <= cg_addr[10:3] ^ {5'h00, cg_addr[2:0]};
	end
endmodule

//--- sim/text_video_serializer_tb_top.sv
// self-checking bench of the text video serializer
// assumes tvs_pkg compiled and the glyph model beside the design
`timescale 1ns/100ps
module text_video_serializer_tb_top;
	logic                ref_clk = 1'b0;
	logic                rst_b = 1'b0;
	logic [3:0]          avs_address = 4'h0;
	logic                avs_read = 1'b0;
	logic                avs_write = 1'b0;
	logic [31:0]         avs_writedata = 32'h0;
	logic [3:0]          avs_byteenable = 4'hF;
	logic [31:0]         avs_readdata;
	logic                avs_waitrequest;
	tvs_pkg::tvs_crtc_s  crtc = '0;
	logic [10:0]         cpu_addr = 11'h000;
	logic                cpu_vram_sel_n = 1'b1;
	logic                cpu_character_ram_sel_n = 1'b1;
	logic                cpu_attribute_ram_sel_n = 1'b1;
	logic                cpu_rd_n = 1'b1;
	logic                cpu_wr_n = 1'b1;
	logic [7:0]          cpu_data_in = 8'h00;
	logic [7:0]          cpu_data_out;
	logic                cpu_data_oe;
	logic [10:0]         cg_addr;
	logic [7:0]          cg_data;
	tvs_pkg::tvs_video_s video;
	logic                bus_hold_request_n;
	logic [31:0]         q;
	int                  n_mismatch = 0;
	int                  compares = 0;

	always #4 ref_clk = ~ref_clk;

	tvs_serializer dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .crtc(crtc),
		.cpu_addr(cpu_addr), .cpu_vram_sel_n(cpu_vram_sel_n),
		.cpu_character_ram_sel_n(cpu_character_ram_sel_n), .cpu_attribute_ram_sel_n(cpu_attribute_ram_sel_n),
		.cpu_rd_n(cpu_rd_n), .cpu_wr_n(cpu_wr_n),
		.cpu_data_in(cpu_data_in), .cpu_data_out(cpu_data_out),
		.cpu_data_oe(cpu_data_oe), .cg_addr(cg_addr), .cg_data(cg_data),
		.video(video), .bus_hold_request_n(bus_hold_request_n));
	tvs_glyph_rom far_u (.ref_clk(ref_clk), .cg_addr(cg_addr),
		.cg_data(cg_data));

	// ======================================================
	// compare and verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		if (n_mismatch == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ======================================================
	// avalon access, held until waitrequest seen low at an edge
	task automatic av(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		// wait for the answer; only the watchdog ends a hang
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// cpu video memory access, data taken two edges after request
	task automatic cpu(input logic ar, input logic wr,
		input logic [10:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		cpu_addr <= a;
		cpu_vram_sel_n <= 1'b0;
		cpu_character_ram_sel_n <= ar;
		cpu_attribute_ram_sel_n <= !ar;
		cpu_wr_n <= !wr;
		cpu_rd_n <= wr;
		cpu_data_in <= d;
		repeat (2) @(posedge ref_clk);
		q = {23'h0, cpu_data_oe, cpu_data_out};
		cpu_vram_sel_n <= 1'b1;
		cpu_character_ram_sel_n <= 1'b1;
		cpu_attribute_ram_sel_n <= 1'b1;
		cpu_wr_n <= 1'b1;
		cpu_rd_n <= 1'b1;
	endtask

	// pixel level after the pipeline has refilled
	task automatic pix(input logic e);
		repeat (600) @(posedge ref_clk);
		repeat (32) begin
			@(posedge ref_clk);
			chk(video.pixel, e);
		end
	endtask

	task automatic vpulse;
		@(posedge ref_clk) crtc.vsync <= 1'b1; // active high sync
		repeat (3) @(posedge ref_clk);
		crtc.vsync <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		report_and_stop;
	end

	// ======================================================
	// main sequence
	initial begin
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		chk({video, bus_hold_request_n}, 32'h5);
		av(1'b0, tvs_pkg::REG_CTRL, 32'h0);
		chk(q, 32'h0);
		av(1'b1, tvs_pkg::REG_CTRL, 32'h3);
		av(1'b0, tvs_pkg::REG_CTRL, 32'h0);
		chk(q, 32'h3);
		avs_byteenable <= 4'h0;
		av(1'b1, tvs_pkg::REG_CTRL, 32'h0);
		avs_byteenable <= 4'hF;
		av(1'b0, tvs_pkg::REG_CTRL, 32'h0);
		chk(q, 32'h3);
		av(1'b0, 4'h8, 32'h0);
		chk(q, 32'h0);
		av(1'b1, tvs_pkg::REG_CTRL, 32'h1);
		cpu(1'b0, 1'b1, 11'h005, 8'hA5);
		cpu(1'b1, 1'b1, 11'h005, 8'h02);
		cpu(1'b0, 1'b0, 11'h005, 8'h00);
		chk(q, 32'h1A5);
		cpu(1'b1, 1'b0, 11'h005, 8'h00);
		chk(q, 32'h1FE);
		@(posedge ref_clk) cpu_rd_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk(cpu_data_oe, 1'b0);
		cpu_rd_n <= 1'b1;
		// refresh address and raster row
		crtc.refresh_addr <= 14'h0005;
		crtc.raster_row <= 5'h1B;
		repeat (300) @(posedge ref_clk);
		chk(cg_addr, 11'h52B);
		crtc.hsync <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk(video.sync_n, 1'b0);
		crtc.hsync <= 1'b0;
		crtc.raster_row <= 5'h00;
		crtc.display_window <= 1'b1; // visible area
		cpu(1'b0, 1'b1, 11'h005, 8'h00);
		cpu(1'b1, 1'b1, 11'h005, 8'h01);
		pix(1'b1);
		cpu(1'b1, 1'b1, 11'h005, 8'h00);
		pix(1'b0);
		cpu(1'b0, 1'b1, 11'h005, 8'hFF);
		pix(1'b1);
		av(1'b1, tvs_pkg::REG_CTRL, 32'h0);
		cpu(1'b1, 1'b1, 11'h005, 8'h02);
		pix(1'b0);
		repeat (32) vpulse;
		pix(1'b1);
		crtc.display_window <= 1'b0;
		pix(1'b0);
		// hold request and display flag
		crtc.display_window <= 1'b1;
		av(1'b1, tvs_pkg::REG_CTRL, 32'h2);
		repeat (3) @(posedge ref_clk);
		chk(bus_hold_request_n, 1'b0);
		av(1'b0, tvs_pkg::REG_STATUS, 32'h0);
		chk(q, 32'h3);
		crtc.display_window <= 1'b0;
		vpulse;
		chk(bus_hold_request_n, 1'b1);
		av(1'b0, tvs_pkg::REG_STATUS, 32'h0);
		chk(q, 32'h2);
		report_and_stop;
	end
endmodule
